/* File: hdl/hspc_pulse_dec.sv */
// Shared constants of the pulse counter and its input pulse decoder.
//
// What this block does
// - Single input: one count per rising count edge, only while counting is enabled.
// - Single input: direction bit on counts down, off counts up.
// - Value is a 32-bit signed ring; max wraps to min and back.
// - Contact sets stepping up onto the setting, clears stepping below it.
// - Counting never stops or saturates at the setting.
// - Reset command with reset-enable on clears value and contact.
// - Retentive counter keeps value, contact and reset state across a warm restart.
// - With external start, counting begins when start rises while enabled.
// - External reset terminal resets the counter at once.
// - Two inputs: up input counts up, down input counts down, while enabled.
// - Two-input and quadrature modes show direction: on down, off up.
// - Two-input and quadrature counters are 32-bit up/down counters.
// - Quadrature: direction taken from the phase of two inputs.
// - Hardware mode: readable value refreshed by command; software mode: every count.
// - At most 32 compare commands, at most one table compare among them.
// - Compare output is driven the moment its comparison resolves.
// - Status shows whether the counter runs in hardware or software mode.
// - Any compare command in use demotes the counter to software mode.
// - Quadrature counts one edge per cycle by default, four when selected.
// - External reset acts on rising terminal, or on falling when inverted.
`timescale 1ns/10ps
package hspc_pkg;
   typedef enum logic [1:0] {
      HSPC_SINGLE,
      HSPC_DUAL,
      HSPC_QUAD
   } hspc_mode_e;

   localparam int          CLK_HZ        = 25000000;
   localparam int          NPINS         = 6;
   localparam int          PIN_A         = 0;
   localparam int          PIN_B         = 1;
   localparam int          PIN_XRST      = 2;
   localparam int          PIN_START     = 3;
   localparam int          PIN_RSTEN     = 4;
   localparam int          PIN_CNTEN     = 5;

   localparam logic [7:0]  ADR_CTRL      = 8'h00;
   localparam logic [7:0]  ADR_CMD       = 8'h04;
   localparam logic [7:0]  ADR_SETTING   = 8'h08;
   localparam logic [7:0]  ADR_VALUE     = 8'h0C;
   localparam logic [7:0]  ADR_STATUS    = 8'h10;
   localparam logic [7:0]  ADR_CMP_VAL   = 8'h14;
   localparam logic [7:0]  ADR_CMP_CTRL  = 8'h18;

   localparam int          CTRL_MODE     = 0;
   localparam int          CTRL_DIR      = 2;
   localparam int          CTRL_RETAIN   = 3;
   localparam int          CTRL_USTART   = 4;
   localparam int          CTRL_UXRST    = 5;
   localparam int          CTRL_RINV     = 6;
   localparam int          CTRL_FOUR     = 7;
   localparam int          CTRL_CSET     = 8;
   localparam int          CTRL_CCLR     = 9;

   localparam int          CMD_RESET     = 0;
   localparam int          CMD_XFER      = 1;
   localparam int          CMD_OUT       = 2;

   localparam int          ST_CONTACT    = 0;
   localparam int          ST_DIR        = 1;
   localparam int          ST_HW         = 2;
   localparam int          ST_RUN        = 3;
   localparam int          ST_CMP        = 4;
   localparam int          ST_ERR        = 5;

   localparam int          CC_TABLE      = 8;
   localparam logic [5:0]  CMP_MAX       = 6'h20;

   localparam logic [31:0] VAL_ZERO      = 32'h00000000;
   localparam logic [31:0] VAL_ONE       = 32'h00000001;
   localparam logic [31:0] VAL_MAX       = 32'h7FFFFFFF;
   localparam logic [31:0] VAL_MIN       = 32'h80000000;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge
endpackage : hspc_pkg

// Turns the synchronised A and B levels into one count step with a direction.
module hspc_pulse_dec (
   input  wire logic               clk_i,
   input  wire logic               rst_b_i,
   input  wire logic               a_i,
   input  wire logic               b_i,
   input  wire hspc_pkg::hspc_mode_e mode_i,
   input  wire logic               four_edge_i,
   input  wire logic               dir_sel_i,
   output logic                    step_o,
   output logic                    down_o
);
   typedef struct packed {
      logic pa;
      logic pb;
      logic step;
      logic down;
   } hspc_dec_s;

   hspc_dec_s q;
   hspc_dec_s n;

   always_comb begin
      n      = q;
      n.pa   = a_i;
      n.pb   = b_i;
      n.step = 1'b0;
      n.down = 1'b0;
      case (mode_i)
         hspc_pkg::HSPC_SINGLE: begin
            n.step = a_i & ~q.pa;
            n.down = dir_sel_i;
         end
         hspc_pkg::HSPC_DUAL: begin
            // Simultaneous up and down edges cancel rather than racing.
            n.step = (a_i & ~q.pa) ^ (b_i & ~q.pb);
            n.down = b_i & ~q.pb;
         end
         hspc_pkg::HSPC_QUAD: begin
            if (four_edge_i) begin
               n.step = (a_i ^ q.pa) ^ (b_i ^ q.pb);
               n.down = ~(a_i ^ q.pb);
            end else begin
               n.step = a_i & ~q.pa;
               n.down = b_i;
            end
         end
         default: begin
            n.step = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign step_o = q.step;
   assign down_o = q.down;
endmodule : hspc_pulse_dec

/* File: hdl/hspc_counter.sv */
// High-speed 32-bit up/down pulse counter with a classic Wishbone register slave.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module hspc_counter (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        count_input_a_i,
   input  wire logic        count_input_b_or_reset_i,
   input  wire logic        ext_reset_terminal_i,
   input  wire logic        ext_start_terminal_i,
   input  wire logic        reset_enable_input_i,
   input  wire logic        count_enable_input_i,
   input  wire logic        warm_restart_i,
   output logic             contact_o,
   output logic             compare_out_o,
   output logic             dir_monitor_o,
   output logic             hw_mode_status_o
);
   typedef struct packed {
      logic [hspc_pkg::NPINS-1:0] s1;
      logic [hspc_pkg::NPINS-1:0] s2;
      logic [hspc_pkg::NPINS-1:0] s3;
      logic [31:0]                value;
      logic [31:0]                shadow;
      logic [31:0]                setting;
      logic [31:0]                cmp_val;
      hspc_pkg::hspc_mode_e       mode;
      logic                       dir_sel;
      logic                       retentive;
      logic                       use_start;
      logic                       use_xrst;
      logic                       rst_inv;
      logic                       four_edge;
      logic                       cmp_set_en;
      logic                       cmp_clr_en;
      logic [5:0]                 cmp_count;
      logic                       cmp_table;
      logic                       cmp_err;
      logic                       running;
      logic                       contact;
      logic                       dir;
      logic                       cmp_out;
      logic                       hw_mode;
      logic                       ack;
      logic [31:0]                rdata;
   } hspc_state_s;

   hspc_state_s q;
   hspc_state_s n;

   logic        step;
   logic        down;
   logic        hw_now;
   logic        xrst_cur;
   logic        xrst_prev;
   logic        xrst_hit;
   logic        start_rise;
   logic        count_ok;
   logic        req;
   logic        wr;
   logic        cmd_wr;
   logic        cmd_reset;
   logic        cmd_xfer;
   logic        warm_clear;
   logic        any_reset;
   logic        do_count;
   logic [31:0] next_value;
   logic [31:0] status_word;
   logic [31:0] ctrl_word;

   hspc_pulse_dec u_dec (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .a_i         (q.s2[hspc_pkg::PIN_A]),
      .b_i         (q.s2[hspc_pkg::PIN_B]),
      .mode_i      (q.mode),
      .four_edge_i (q.four_edge),
      .dir_sel_i   (q.dir_sel),
      .step_o      (step),
      .down_o      (down)
   );

   // Any compare command in use takes the counter off the fast path.
   assign hw_now = (q.cmp_count == 6'h00) & ~q.cmp_table & ~q.cmp_set_en & ~q.cmp_clr_en;

   // In single-input mode the B pin doubles as the external reset terminal.
   assign xrst_cur   = (q.mode == hspc_pkg::HSPC_SINGLE) ? q.s2[hspc_pkg::PIN_B] : q.s2[hspc_pkg::PIN_XRST];
   assign xrst_prev  = (q.mode == hspc_pkg::HSPC_SINGLE) ? q.s3[hspc_pkg::PIN_B] : q.s3[hspc_pkg::PIN_XRST];
   assign xrst_hit   = q.use_xrst & (q.rst_inv ? (xrst_prev & ~xrst_cur) : (~xrst_prev & xrst_cur));
   assign start_rise = q.use_start & q.s2[hspc_pkg::PIN_START] & ~q.s3[hspc_pkg::PIN_START]
                       & q.s2[hspc_pkg::PIN_CNTEN];
   assign count_ok   = q.s2[hspc_pkg::PIN_CNTEN] & (~q.use_start | q.running);

   assign req        = wb_cyc_i & wb_stb_i & ~q.ack;
   assign wr         = req & wb_we_i;
   assign cmd_wr     = wr & (wb_adr_i == hspc_pkg::ADR_CMD) & wb_sel_i[0];
   assign cmd_reset  = cmd_wr & wb_dat_i[hspc_pkg::CMD_RESET] & q.s2[hspc_pkg::PIN_RSTEN];
   assign cmd_xfer   = cmd_wr & (wb_dat_i[hspc_pkg::CMD_XFER] | wb_dat_i[hspc_pkg::CMD_OUT]);
   assign warm_clear = warm_restart_i & ~q.retentive;
   assign any_reset  = cmd_reset | xrst_hit | warm_clear;
   assign do_count   = step & count_ok & ~any_reset;
   // Plain 32-bit arithmetic gives the signed ring for free.
   assign next_value = down ? (q.value - hspc_pkg::VAL_ONE) : (q.value + hspc_pkg::VAL_ONE);

   always_comb begin
      status_word                       = 32'h00000000;
      status_word[hspc_pkg::ST_CONTACT] = q.contact;
      status_word[hspc_pkg::ST_DIR]     = q.dir;
      status_word[hspc_pkg::ST_HW]      = q.hw_mode;
      status_word[hspc_pkg::ST_RUN]     = q.running;
      status_word[hspc_pkg::ST_CMP]     = q.cmp_out;
      status_word[hspc_pkg::ST_ERR]     = q.cmp_err;
      ctrl_word                                     = 32'h00000000;
      ctrl_word[hspc_pkg::CTRL_MODE +: 2]           = q.mode;
      ctrl_word[hspc_pkg::CTRL_DIR]                 = q.dir_sel;
      ctrl_word[hspc_pkg::CTRL_RETAIN]              = q.retentive;
      ctrl_word[hspc_pkg::CTRL_USTART]              = q.use_start;
      ctrl_word[hspc_pkg::CTRL_UXRST]               = q.use_xrst;
      ctrl_word[hspc_pkg::CTRL_RINV]                = q.rst_inv;
      ctrl_word[hspc_pkg::CTRL_FOUR]                = q.four_edge;
      ctrl_word[hspc_pkg::CTRL_CSET]                = q.cmp_set_en;
      ctrl_word[hspc_pkg::CTRL_CCLR]                = q.cmp_clr_en;
   end

   always_comb begin
      n         = q;
      n.s1      = {count_enable_input_i, reset_enable_input_i, ext_start_terminal_i,
                   ext_reset_terminal_i, count_input_b_or_reset_i, count_input_a_i};
      n.s2      = q.s1;
      n.s3      = q.s2;
      n.hw_mode = hw_now;
      n.ack     = req;

      if (start_rise) begin
         n.running = 1'b1;
      end

      if (do_count) begin
         n.value = next_value;
         if (!down && next_value == q.setting) begin
            n.contact = 1'b1;
         end
         if (down && q.value == q.setting) begin
            n.contact = 1'b0;
         end
         if (q.cmp_set_en && next_value == q.cmp_val) begin
            n.cmp_out = 1'b1;
         end
         if (q.cmp_clr_en && next_value == q.cmp_val) begin
            n.cmp_out = 1'b0;
         end
         if (q.mode != hspc_pkg::HSPC_SINGLE) begin
            n.dir = down;
         end
         if (!hw_now) begin
            n.shadow = next_value;
         end
      end
      if (q.mode == hspc_pkg::HSPC_SINGLE) begin
         n.dir = q.dir_sel;
      end

      if (cmd_xfer) begin
         n.shadow = q.value;
      end

      if (any_reset) begin
         n.value   = hspc_pkg::VAL_ZERO;
         n.shadow  = hspc_pkg::VAL_ZERO;
         n.contact = 1'b0;
         n.running = 1'b0;
      end

      if (wr) begin
         case (wb_adr_i)
            hspc_pkg::ADR_CTRL: begin
               if (wb_sel_i[0]) begin
                  // Code 3 names no mode, so it leaves the mode alone.
                  if (wb_dat_i[hspc_pkg::CTRL_MODE +: 2] != 2'h3) begin
                     n.mode = hspc_pkg::hspc_mode_e'(wb_dat_i[hspc_pkg::CTRL_MODE +: 2]);
                  end
                  n.dir_sel   = wb_dat_i[hspc_pkg::CTRL_DIR];
                  n.retentive = wb_dat_i[hspc_pkg::CTRL_RETAIN];
                  n.use_start = wb_dat_i[hspc_pkg::CTRL_USTART];
                  n.use_xrst  = wb_dat_i[hspc_pkg::CTRL_UXRST];
                  n.rst_inv   = wb_dat_i[hspc_pkg::CTRL_RINV];
                  n.four_edge = wb_dat_i[hspc_pkg::CTRL_FOUR];
               end
               if (wb_sel_i[1]) begin
                  n.cmp_set_en = wb_dat_i[hspc_pkg::CTRL_CSET];
                  n.cmp_clr_en = wb_dat_i[hspc_pkg::CTRL_CCLR];
               end
            end
            hspc_pkg::ADR_SETTING: begin
               n.setting = hspc_pkg::merge(q.setting, wb_dat_i, wb_sel_i);
            end
            hspc_pkg::ADR_CMP_VAL: begin
               n.cmp_val = hspc_pkg::merge(q.cmp_val, wb_dat_i, wb_sel_i);
            end
            hspc_pkg::ADR_CMP_CTRL: begin
               // A table compare counts among the 32, so it needs a count of one or more.
               if (wb_dat_i[5:0] > hspc_pkg::CMP_MAX ||
                   (wb_dat_i[hspc_pkg::CC_TABLE] && wb_dat_i[5:0] == 6'h00)) begin
                  n.cmp_err = 1'b1;
               end else if (wb_sel_i[0] && wb_sel_i[1]) begin
                  n.cmp_count = wb_dat_i[5:0];
                  n.cmp_table = wb_dat_i[hspc_pkg::CC_TABLE];
                  n.cmp_err   = 1'b0;
               end
            end
            default: begin
               n.cmp_err = q.cmp_err;
            end
         endcase
      end

      if (req) begin
         case (wb_adr_i)
            hspc_pkg::ADR_CTRL:     n.rdata = ctrl_word;
            hspc_pkg::ADR_SETTING:  n.rdata = q.setting;
            hspc_pkg::ADR_VALUE:    n.rdata = q.shadow;
            hspc_pkg::ADR_STATUS:   n.rdata = status_word;
            hspc_pkg::ADR_CMP_VAL:  n.rdata = q.cmp_val;
            hspc_pkg::ADR_CMP_CTRL: n.rdata = {23'h000000, q.cmp_table, 2'h0, q.cmp_count};
            default:                n.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign wb_dat_o         = q.rdata;
   assign wb_ack_o         = q.ack;
   assign contact_o        = q.contact;
   assign compare_out_o    = q.cmp_out;
   assign dir_monitor_o    = q.dir;
   assign hw_mode_status_o = q.hw_mode;

   sequence s_step_onto_setting;
      do_count && !down && (next_value == q.setting);
   endsequence

   sequence s_step_off_setting;
      do_count && down && (q.value == q.setting);
   endsequence

   property p_contact_set;
      @(posedge clk_i) disable iff (!rst_b_i)
         s_step_onto_setting |=> contact_o;
   endproperty
   a_contact_set: assert property (p_contact_set) else $error("contact not set on reaching setting");

   property p_contact_clr;
      @(posedge clk_i) disable iff (!rst_b_i)
         s_step_off_setting |=> !contact_o;
   endproperty
   a_contact_clr: assert property (p_contact_clr) else $error("contact not cleared below setting");

   property p_wrap_up;
      @(posedge clk_i) disable iff (!rst_b_i)
         (do_count && !down && q.value == hspc_pkg::VAL_MAX) |=> (q.value == hspc_pkg::VAL_MIN);
   endproperty
   a_wrap_up: assert property (p_wrap_up) else $error("no wrap from max to min");

   property p_wrap_dn;
      @(posedge clk_i) disable iff (!rst_b_i)
         (do_count && down && q.value == hspc_pkg::VAL_MIN) |=> (q.value == hspc_pkg::VAL_MAX);
   endproperty
   a_wrap_dn: assert property (p_wrap_dn) else $error("no wrap from min to max");

   property p_cmd_reset;
      @(posedge clk_i) disable iff (!rst_b_i)
         cmd_reset |=> (q.value == hspc_pkg::VAL_ZERO) && !contact_o;
   endproperty
   a_cmd_reset: assert property (p_cmd_reset) else $error("reset command did not clear");

   property p_ext_reset;
      @(posedge clk_i) disable iff (!rst_b_i)
         xrst_hit |=> (q.value == hspc_pkg::VAL_ZERO) && !q.running;
   endproperty
   a_ext_reset: assert property (p_ext_reset) else $error("external reset did not clear");

   property p_hold_disabled;
      @(posedge clk_i) disable iff (!rst_b_i)
         (!count_ok && !any_reset) |=> $stable(q.value);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled) else $error("value moved while disabled");

   property p_sw_shadow;
      @(posedge clk_i) disable iff (!rst_b_i)
         (do_count && !hw_now && !cmd_xfer) |=> (q.shadow == q.value);
   endproperty
   a_sw_shadow: assert property (p_sw_shadow) else $error("software value not refreshed");

   property p_hw_hold;
      @(posedge clk_i) disable iff (!rst_b_i)
         (hw_now && !cmd_xfer && !any_reset) |=> $stable(q.shadow);
   endproperty
   a_hw_hold: assert property (p_hw_hold) else $error("hardware value refreshed without command");

   property p_demote;
      @(posedge clk_i) disable iff (!rst_b_i)
         (q.cmp_set_en || q.cmp_clr_en || q.cmp_count != 6'h00) |=> !hw_mode_status_o;
   endproperty
   a_demote: assert property (p_demote) else $error("hardware mode kept with compare in use");

   property p_dir_monitor;
      @(posedge clk_i) disable iff (!rst_b_i)
         (do_count && q.mode != hspc_pkg::HSPC_SINGLE) |=> (dir_monitor_o == $past(down));
   endproperty
   a_dir_monitor: assert property (p_dir_monitor) else $error("direction monitor wrong");

   // A step that lands on the compare value with clear enabled must drop the output, even if set is also enabled.
   property p_cmp_clear;
      @(posedge clk_i) disable iff (!rst_b_i)
         (do_count && q.cmp_clr_en && next_value == q.cmp_val) |=> !compare_out_o;
   endproperty
   a_cmp_clear: assert property (p_cmp_clear) else $error("compare output not cleared");
endmodule : hspc_counter

/* File: test/hspc_pulse_src.sv */
// Behavioural encoder and pulse source that drives the counter's A and B pins.
`timescale 1ns/10ps
module hspc_pulse_src (
   input  wire logic clk_i,
   output logic      a_o,
   output logic      b_o
);
   initial begin
      a_o = 1'b0;
      b_o = 1'b0;
   end

   // Every level is held five edges so that the synchroniser and the decoder always see it.
   task automatic hold(input logic a, input logic b);
      @(posedge clk_i);
      a_o <= a;
      b_o <= b;
      repeat (4) @(posedge clk_i);
   endtask : hold

   task automatic pulse(input logic on_b, input int n);
      repeat (n) begin
         hold(!on_b, on_b);
         hold(1'b0, 1'b0);
      end
   endtask : pulse

   // The phases stay a quarter cycle apart; A leads when up is set.
   task automatic quad(input logic up, input int n);
      repeat (n) begin
         hold(up, !up);
         hold(1'b1, 1'b1);
         hold(!up, up);
         hold(1'b0, 1'b0);
      end
   endtask : quad
endmodule : hspc_pulse_src

/* File: test/tb.sv */
// Self-checking testbench of the pulse counter: register tasks and encoder-driven scenarios.
`timescale 1ns/10ps
`define CHK(w, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s expected %h seen %h", w, e, g); end end
module tb;
   logic        clk   = 1'b0;
   logic        rst_b = 1'b0;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'hF;
   logic [31:0] wdat  = 32'h00000000;
   logic        xrst  = 1'b0;
   logic        start = 1'b0;
   logic        rsten = 1'b0;
   logic        cnten = 1'b0;
   logic        warm  = 1'b0;
   logic [31:0] rdat;
   logic [31:0] v;
   logic        ack, a, b, contact, cmp_out, dir_mon, hw;
   int          num_errors = 0;
   int          checks     = 0;

   hspc_counter dut (.clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .count_input_a_i(a), .count_input_b_or_reset_i(b), .ext_reset_terminal_i(xrst),
      .ext_start_terminal_i(start), .reset_enable_input_i(rsten), .count_enable_input_i(cnten),
      .warm_restart_i(warm), .contact_o(contact), .compare_out_o(cmp_out),
      .dir_monitor_o(dir_mon), .hw_mode_status_o(hw));
   hspc_pulse_src src (.clk_i(clk), .a_o(a), .b_o(b));

   initial begin
      forever #20 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   // The request stands until ack is sampled high; only the watchdog ends a wait.
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= ad;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, ad, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] q);
      wb(1'b0, ad, 32'h00000000, q);
   endtask : rd

   // Hardware mode only refreshes the readable value on a transfer command.
   task automatic cnt(output logic [31:0] q);
      wr(hspc_pkg::ADR_CMD, 32'h00000002);
      rd(hspc_pkg::ADR_VALUE, q);
   endtask : cnt

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   task automatic pin_pulse_warm();
      warm <= 1'b1;
      wt(1);
      warm <= 1'b0;
      wt(2);
   endtask : pin_pulse_warm

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   initial begin
      wt(4);
      rst_b <= 1'b1;
      wt(2);
      `CHK("hw mode", 1'b1, hw)
      rd(hspc_pkg::ADR_CTRL, v);
      `CHK("ctrl reset", 32'h00000000, v)
      rd(8'h1C, v);
      `CHK("unmapped", 32'h00000000, v)
      cnten <= 1'b1;
      src.pulse(1'b0, 3);
      cnt(v);
      `CHK("single up", 32'h00000003, v)
      cnten <= 1'b0;
      src.pulse(1'b0, 2);
      cnten <= 1'b1;
      src.pulse(1'b0, 1);
      rd(hspc_pkg::ADR_VALUE, v);
      `CHK("stale shadow", 32'h00000003, v)
      cnt(v);
      `CHK("enable gate", 32'h00000004, v)
      wr(hspc_pkg::ADR_SETTING, 32'h00000005);
      src.pulse(1'b0, 1);
      `CHK("contact set", 1'b1, contact)
      src.pulse(1'b0, 1);
      cnt(v);
      `CHK("past setting", 32'h00000006, v)
      wr(hspc_pkg::ADR_CTRL, 32'h00000004);
      src.pulse(1'b0, 1);
      `CHK("down dir", 1'b1, dir_mon)
      `CHK("contact held", 1'b1, contact)
      rsten <= 1'b0;
      wr(hspc_pkg::ADR_CMD, 32'h00000001);
      cnt(v);
      `CHK("reset gated", 32'h00000005, v)
      rsten <= 1'b1;
      wt(3);
      wr(hspc_pkg::ADR_CMD, 32'h00000001);
      cnt(v);
      `CHK("reset value", 32'h00000000, v)
      `CHK("reset contact", 1'b0, contact)
      wr(hspc_pkg::ADR_SETTING, 32'h00000001);
      wr(hspc_pkg::ADR_CTRL, 32'h00000001);
      src.pulse(1'b0, 2);
      `CHK("dual contact", 1'b1, contact)
      src.pulse(1'b1, 2);
      `CHK("contact clear", 1'b0, contact)
      `CHK("dual dir down", 1'b1, dir_mon)
      src.pulse(1'b1, 1);
      cnt(v);
      `CHK("dual value", 32'hFFFFFFFF, v)
      src.pulse(1'b0, 1);
      `CHK("dual dir up", 1'b0, dir_mon)
      wr(hspc_pkg::ADR_CTRL, 32'h00000002);
      src.quad(1'b1, 3);
      cnt(v);
      `CHK("quad up", 32'h00000003, v)
      src.quad(1'b0, 1);
      `CHK("quad dir", 1'b1, dir_mon)
      cnt(v);
      `CHK("quad down", 32'h00000002, v)
      wr(hspc_pkg::ADR_CTRL, 32'h00000082);
      src.quad(1'b1, 1);
      cnt(v);
      `CHK("four edge", 32'h00000006, v)
      wr(hspc_pkg::ADR_CTRL, 32'h00000022);
      xrst <= 1'b1;
      wt(6);
      cnt(v);
      `CHK("ext reset", 32'h00000000, v)
      xrst <= 1'b0;
      wt(6);
      src.quad(1'b1, 1);
      wr(hspc_pkg::ADR_CTRL, 32'h00000062);
      xrst <= 1'b1;
      wt(6);
      wr(hspc_pkg::ADR_CMD, 32'h00000004);
      rd(hspc_pkg::ADR_VALUE, v);
      `CHK("inverted rise", 32'h00000001, v)
      xrst <= 1'b0;
      wt(6);
      cnt(v);
      `CHK("inverted fall", 32'h00000000, v)
      wr(hspc_pkg::ADR_CTRL, 32'h00000012);
      src.quad(1'b1, 1);
      cnt(v);
      `CHK("before start", 32'h00000000, v)
      start <= 1'b1;
      wt(6);
      src.quad(1'b1, 2);
      cnt(v);
      `CHK("after start", 32'h00000002, v)
      wr(hspc_pkg::ADR_CTRL, 32'h0000000A);
      pin_pulse_warm();
      cnt(v);
      `CHK("retained", 32'h00000002, v)
      wr(hspc_pkg::ADR_CTRL, 32'h00000002);
      pin_pulse_warm();
      cnt(v);
      `CHK("not retained", 32'h00000000, v)
      wr(hspc_pkg::ADR_CMP_VAL, 32'h00000002);
      wr(hspc_pkg::ADR_CTRL, 32'h00000102);
      wr(hspc_pkg::ADR_CMP_CTRL, 32'h00000001);
      wt(1);
      `CHK("demoted", 1'b0, hw)
      src.quad(1'b1, 1);
      rd(hspc_pkg::ADR_VALUE, v);
      `CHK("soft shadow", 32'h00000001, v)
      src.quad(1'b1, 1);
      `CHK("compare out", 1'b1, cmp_out)
      wr(hspc_pkg::ADR_CTRL, 32'h00000202);
      src.quad(1'b0, 1);
      `CHK("compare kept", 1'b1, cmp_out)
      src.quad(1'b1, 1);
      `CHK("compare clear", 1'b0, cmp_out)
      wr(hspc_pkg::ADR_CMP_CTRL, 32'h00000021);
      rd(hspc_pkg::ADR_STATUS, v);
      `CHK("over limit", 1'b1, v[hspc_pkg::ST_ERR])
      wr(hspc_pkg::ADR_CMP_CTRL, 32'h00000020);
      rd(hspc_pkg::ADR_STATUS, v);
      `CHK("at limit", 1'b0, v[hspc_pkg::ST_ERR])
      wr(hspc_pkg::ADR_CMP_CTRL, 32'h00000100);
      rd(hspc_pkg::ADR_STATUS, v);
      `CHK("table alone", 1'b1, v[hspc_pkg::ST_ERR])
      wr(hspc_pkg::ADR_CMP_CTRL, 32'h00000101);
      rd(hspc_pkg::ADR_CMP_CTRL, v);
      `CHK("table kept", 32'h00000101, v)
      wr(hspc_pkg::ADR_CMP_CTRL, 32'h00000000);
      wr(hspc_pkg::ADR_CTRL, 32'h00000002);
      wt(2);
      `CHK("hw again", 1'b1, hw)
      wrap_up();
   end
endmodule : tb
